// *** pkg/adc_ovs_params.svh ***
// register offsets, field positions, reset values and timing counts of the converter back-end
`ifndef ADC_OVS_PARAMS_SVH
`define ADC_OVS_PARAMS_SVH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define OFS_STATUS 12'h000
`define OFS_CTRL_A 12'h004
`define OFS_CTRL_B 12'h008
`define OFS_SAMPLE 12'h00c
`define OFS_OVS_CTRL 12'h010
`define OFS_RESULT 12'h014

// ********************************************************************
// field positions
// ********************************************************************
`define BIT_WD_FLAG 0
`define BIT_SEQ_DONE 1
`define BIT_STARTED 4
`define BIT_SEQ_IRQ_EN 5
`define BIT_WD_IRQ_EN 6
`define POS_RES_LO 24
`define POS_RES_HI 25
`define BIT_CONV_ON 0
`define BIT_CONTINUOUS 1
`define BIT_SW_START 22
`define BIT_SENSOR_EN 23
`define POS_SMP_HI 7
`define BIT_OVS_EN 0
`define POS_RATIO_LO 2
`define POS_RATIO_HI 4
`define POS_SHIFT_LO 5
`define POS_SHIFT_HI 8

// ********************************************************************
// reset values and widths
// ********************************************************************
`define RST_WORD 32'h0000_0000
`define ACC_WIDTH 20
`define RESULT_WIDTH 16
`define RAW_WIDTH 12

// ********************************************************************
// timing: conversion phase cycles per resolution (x.5 plus the half of sampling)
// ********************************************************************
`define CONV_CYC_12 8'h0d
`define CONV_CYC_10 8'h0b
`define CONV_CYC_8 8'h09
`define CONV_CYC_6 8'h07

`endif

// *** pkg/adc_ovs_pkg.sv ***
// types shared by the converter back-end
package adc_ovs_pkg;

  // gray along idle -> sample -> convert
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_sample = 2'b01,
    st_convert = 2'b11
  } conv_state_type;

  typedef enum logic [1:0] {
    res_12bit = 2'b00,
    res_10bit = 2'b01,
    res_8bit = 2'b10,
    res_6bit = 2'b11
  } resolution_type;

endpackage

// *** rtl/ovs_round_shift.sv ***
// rounding right shift and truncation of the oversampling sum
`timescale 1ns/10ps
`include "adc_ovs_params.svh"
module ovs_round_shift #(
  parameter int ACC_W = `ACC_WIDTH,
  parameter int OUT_W = `RESULT_WIDTH
) (
  input wire logic [ACC_W-1:0] sum, // accumulated sum
  input wire logic [3:0] shift, // right shift 0..15
  output logic [OUT_W-1:0] result // rounded, truncated result
);
  logic [ACC_W:0] wide;
  logic [ACC_W:0] half;
  logic [ACC_W:0] shifted;

  always_comb begin
    half = '0;
    if (shift != 4'h0) begin
      half = (ACC_W+1)'(1) << (shift - 4'h1);
    end
    wide = {1'b0, sum} + half;
    shifted = wide >> shift;
    result = shifted[OUT_W-1:0];
  end
endmodule

// *** rtl/adc_oversample_resolution_ctrl.sv ***
// converter back-end: sensor enables, resolution timing, oversampling and flags over apb
`timescale 1ns/10ps
`include "adc_ovs_params.svh"
module adc_oversample_resolution_ctrl
  import adc_ovs_pkg::*;
#(
  parameter int ACC_W = `ACC_WIDTH,
  parameter int RAW_W = `RAW_WIDTH
) (
  input wire logic pclk, // apb clock, also converter clock
  input wire logic presetn, // async reset, active low
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ext_trigger, // external conversion trigger, rising edge
  input wire logic [RAW_W-1:0] core_data, // analog core result, right aligned
  input wire logic watchdog_hit, // threshold monitor event pulse
  output logic temp_sensor_enable, // temperature sensor power (channel 16)
  output logic ref_voltage_enable, // reference voltage enable (channel 17)
  output logic sample_hold, // analog core in sampling phase
  output logic convert_run, // analog core in approximation phase
  output logic [1:0] core_resolution, // resolution to analog core
  output logic irq_seq_done, // sequence-done interrupt
  output logic irq_watchdog // watchdog interrupt
);
  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [7:0] conv_cycles(input logic [1:0] res);
    case (res)
      res_12bit: conv_cycles = `CONV_CYC_12;
      res_10bit: conv_cycles = `CONV_CYC_10;
      res_8bit: conv_cycles = `CONV_CYC_8;
      default: conv_cycles = `CONV_CYC_6;
    endcase
  endfunction
  function automatic logic [RAW_W-1:0] res_mask(input logic [1:0] res);
    case (res)
      res_12bit: res_mask = 12'hfff;
      res_10bit: res_mask = 12'h3ff;
      res_8bit: res_mask = 12'h0ff;
      default: res_mask = 12'h03f;
    endcase
  endfunction
  // ********************************************************************
  // registers and bus strobes
  // ********************************************************************
  logic [1:0] res_q;
  logic seq_irq_en_q, wd_irq_en_q;
  logic conv_on_q, cont_q, sens_en_q, ovs_en_q;
  logic [7:0] smp_q;
  logic [2:0] ratio_q;
  logic [3:0] shift_q;
  logic [15:0] data_q, ovs_result;
  logic seq_done_q, wd_flag_q, started_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdata;
  logic mapped, wr_en, rd_en, sw_start;
  conv_state_type state_q, state_d;
  logic [7:0] cnt_q;
  logic [8:0] grp_q, ratio_last;
  logic [ACC_W-1:0] acc_q, acc_sum;
  logic trig_q, pend_q;
  logic sample_q, convert_q;
  logic conv_done, group_done, result_load;
  logic [RAW_W-1:0] raw;
  logic irq_seq_q, irq_wd_q;
  logic stat_wr, result_rd;
  // access completes on the second access cycle, when pready is already high
  assign wr_en = psel & penable & pready_q & pwrite;
  assign rd_en = psel & penable & pready_q & ~pwrite;
  assign sw_start = wr_en & (paddr == `OFS_CTRL_B) & pwdata[`BIT_SW_START];
  always_comb begin
    rdata = `RST_WORD;
    mapped = 1'b1;
    if (paddr == `OFS_STATUS) begin
      rdata[`BIT_WD_FLAG] = wd_flag_q;
      rdata[`BIT_SEQ_DONE] = seq_done_q;
      rdata[`BIT_STARTED] = started_q;
    end else if (paddr == `OFS_CTRL_A) begin
      rdata[`POS_RES_HI:`POS_RES_LO] = res_q;
      rdata[`BIT_SEQ_IRQ_EN] = seq_irq_en_q;
      rdata[`BIT_WD_IRQ_EN] = wd_irq_en_q;
    end else if (paddr == `OFS_CTRL_B) begin
      rdata[`BIT_CONV_ON] = conv_on_q;
      rdata[`BIT_CONTINUOUS] = cont_q;
      rdata[`BIT_SENSOR_EN] = sens_en_q;
    end else if (paddr == `OFS_SAMPLE) begin
      rdata[`POS_SMP_HI:0] = smp_q;
    end else if (paddr == `OFS_OVS_CTRL) begin
      rdata[`BIT_OVS_EN] = ovs_en_q;
      rdata[`POS_RATIO_HI:`POS_RATIO_LO] = ratio_q;
      rdata[`POS_SHIFT_HI:`POS_SHIFT_LO] = shift_q;
    end else if (paddr == `OFS_RESULT) begin
      rdata[15:0] = data_q;
    end else begin
      mapped = 1'b0;
    end
  end
  // ********************************************************************
  // apb answer: one wait state, data and error registered
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `RST_WORD;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= rdata;
      end
    end
  end
  // ********************************************************************
  // control registers
  // ********************************************************************
  // resolution and oversampling settings are frozen while converting,
  // so a careless write cannot split one group over two settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= 2'h0;
      seq_irq_en_q <= 1'b0;
      wd_irq_en_q <= 1'b0;
      conv_on_q <= 1'b0;
      cont_q <= 1'b0;
      sens_en_q <= 1'b0;
      smp_q <= 8'h00;
      ovs_en_q <= 1'b0;
      ratio_q <= 3'h0;
      shift_q <= 4'h0;
    end else if (wr_en) begin
      if (paddr == `OFS_CTRL_A) begin
        if (!conv_on_q) begin
          res_q <= pwdata[`POS_RES_HI:`POS_RES_LO];
        end
        seq_irq_en_q <= pwdata[`BIT_SEQ_IRQ_EN];
        wd_irq_en_q <= pwdata[`BIT_WD_IRQ_EN];
      end else if (paddr == `OFS_CTRL_B) begin
        conv_on_q <= pwdata[`BIT_CONV_ON];
        cont_q <= pwdata[`BIT_CONTINUOUS];
        sens_en_q <= pwdata[`BIT_SENSOR_EN];
      end else if (paddr == `OFS_SAMPLE) begin
        smp_q <= pwdata[`POS_SMP_HI:0];
      end else if (paddr == `OFS_OVS_CTRL && !conv_on_q) begin
        ovs_en_q <= pwdata[`BIT_OVS_EN];
        ratio_q <= pwdata[`POS_RATIO_HI:`POS_RATIO_LO];
        shift_q <= pwdata[`POS_SHIFT_HI:`POS_SHIFT_LO];
      end
    end
  end
  // ********************************************************************
  // conversion sequencer
  // ********************************************************************
  assign raw = core_data & res_mask(res_q);
  assign ratio_last = (9'h002 << ratio_q) - 9'h001;
  assign conv_done = (state_q == st_convert) && (cnt_q == 8'h00);
  assign group_done = (grp_q == ratio_last);
  assign result_load = conv_done & (~ovs_en_q | group_done);
  assign acc_sum = acc_q + {{(ACC_W-RAW_W){1'b0}}, raw};
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (conv_on_q && pend_q) begin
          state_d = st_sample;
        end
      end
      st_sample: begin
        if (cnt_q == 8'h00) begin
          state_d = st_convert;
        end
      end
      default: begin
        if (cnt_q == 8'h00) begin
          // an unfinished group runs on, reloading the sampling time from smp_q, which stays writable while on
          if ((ovs_en_q && !group_done) || cont_q) begin
            state_d = st_sample;
          end else begin
            state_d = st_idle;
          end
        end
      end
    endcase
    if (!conv_on_q) begin
      state_d = st_idle;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      cnt_q <= 8'h00;
      sample_q <= 1'b0;
      convert_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sample_q <= (state_d == st_sample);
      convert_q <= (state_d == st_convert);
      if (state_d == st_sample && state_q != st_sample) begin
        cnt_q <= smp_q;
      end else if (state_d == st_convert && state_q != st_convert) begin
        cnt_q <= conv_cycles(res_q) - 8'h01;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  // a trigger while busy is held and served when the sequencer returns to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      trig_q <= ext_trigger;
      if (!conv_on_q) begin
        pend_q <= 1'b0;
      end else if (sw_start || (ext_trigger && !trig_q)) begin
        pend_q <= 1'b1;
      end else if (state_q == st_idle) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // oversampling accumulator and result
  // ********************************************************************
  ovs_round_shift #(
    .ACC_W(ACC_W),
    .OUT_W(`RESULT_WIDTH)
  ) u_round (
    .sum(acc_sum),
    .shift(shift_q),
    .result(ovs_result)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      grp_q <= 9'h000;
      data_q <= 16'h0000;
    end else begin
      if (!conv_on_q || result_load) begin
        acc_q <= '0;
        grp_q <= 9'h000;
      end else if (conv_done && ovs_en_q) begin
        acc_q <= acc_sum;
        grp_q <= grp_q + 9'h001;
      end
      if (result_load) begin
        data_q <= ovs_en_q ? ovs_result : {4'h0, raw};
      end
    end
  end
  // ********************************************************************
  // status flags: a set in the clearing cycle wins
  // ********************************************************************
  assign stat_wr = wr_en & (paddr == `OFS_STATUS);
  assign result_rd = rd_en & (paddr == `OFS_RESULT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_done_q <= 1'b0;
      wd_flag_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      if (result_load) begin
        seq_done_q <= 1'b1;
      end else if ((stat_wr && !pwdata[`BIT_SEQ_DONE]) || result_rd) begin
        seq_done_q <= 1'b0;
      end
      if (watchdog_hit) begin
        wd_flag_q <= 1'b1;
      end else if (stat_wr && !pwdata[`BIT_WD_FLAG]) begin
        wd_flag_q <= 1'b0;
      end
      if (state_q == st_idle && state_d == st_sample) begin
        started_q <= 1'b1;
      end else if (stat_wr && !pwdata[`BIT_STARTED]) begin
        started_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_seq_q <= 1'b0;
      irq_wd_q <= 1'b0;
    end else begin
      irq_seq_q <= seq_done_q & seq_irq_en_q;
      irq_wd_q <= wd_flag_q & wd_irq_en_q;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign temp_sensor_enable = sens_en_q;
  assign ref_voltage_enable = sens_en_q;
  assign sample_hold = sample_q;
  assign convert_run = convert_q;
  assign core_resolution = res_q;
  assign irq_seq_done = irq_seq_q;
  assign irq_watchdog = irq_wd_q;

endmodule

// *** verification/adc_ovs_assertions.sv ***
// checker of the converter back-end port behaviour
`timescale 1ns/10ps
`include "adc_ovs_params.svh"
module adc_ovs_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic watchdog_hit, // monitor event
  input wire logic temp_sensor_enable, // sensor power
  input wire logic ref_voltage_enable, // reference enable
  input wire logic sample_hold, // sampling phase
  input wire logic convert_run, // approximation phase
  input wire logic [1:0] core_resolution, // resolution
  input wire logic irq_seq_done, // sequence irq
  input wire logic irq_watchdog // watchdog irq
);
  logic [7:0] run_len_q;
  logic run_prev_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********
  // approximation length, held after the phase ends
  // ********
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len_q <= 8'h00;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= convert_run;
      if (convert_run && !run_prev_q) begin
        run_len_q <= 8'h01;
      end else if (convert_run) begin
        run_len_q <= run_len_q + 8'h01;
      end
    end
  end
  // ********
  // assertions
  // ********
  AST_SENSOR_PAIR: assert property (temp_sensor_enable == ref_voltage_enable)
    else $error("sensor and reference enables differ");
  AST_SENSOR_BY_WRITE: assert property ($changed(temp_sensor_enable) |-> $past(pready && pwrite))
    else $error("sensor power changed without a write");
  AST_CONV_LEN: assert property ($fell(convert_run) |-> run_len_q == 8'h0d - {5'h00, core_resolution, 1'b0})
    else $error("approximation length wrong for resolution");
  AST_SAMPLE_TO_CONV: assert property ($fell(sample_hold) |-> convert_run && !sample_hold)
    else $error("sampling not followed by approximation");
  AST_RES_HELD: assert property (convert_run |-> $stable(core_resolution))
    else $error("resolution changed during conversion");
  AST_SEQ_IRQ_CAUSE: assert property ($rose(irq_seq_done) |-> $past(convert_run, 2) || $past(pready && pwrite, 2))
    else $error("sequence irq without conversion end or enable write");
  AST_SEQ_IRQ_FALL: assert property ($fell(irq_seq_done) |-> $past(pready, 2))
    else $error("sequence irq dropped without software access");
  AST_WD_IRQ_CAUSE: assert property ($rose(irq_watchdog) |-> $past(watchdog_hit, 2) || $past(pready && pwrite, 2))
    else $error("watchdog irq without event or enable write");
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  cover property ($fell(convert_run) && core_resolution == 2'b11);
  cover property ($rose(irq_seq_done));
  cover property ($rose(irq_watchdog));
endmodule

bind adc_oversample_resolution_ctrl adc_ovs_checker checker_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .watchdog_hit(watchdog_hit),
  .temp_sensor_enable(temp_sensor_enable), .ref_voltage_enable(ref_voltage_enable), .sample_hold(sample_hold),
  .convert_run(convert_run), .core_resolution(core_resolution), .irq_seq_done(irq_seq_done),
  .irq_watchdog(irq_watchdog));

// *** verification/analog_core_model.sv ***
// behavioural model of the analog converter core
`timescale 1ns/10ps
module analog_core_model (
  input wire logic convert_run, // approximation phase
  input wire logic [11:0] level, // input level set by the bench
  output logic [11:0] core_data // result to the back-end
);
  // lines are not valid outside approximation, so show the inverse rather than a stale value
  assign core_data = convert_run ? level : ~level;
endmodule

// *** verification/adc_oversample_resolution_ctrl_bench.sv ***
// self-checking bench of the converter back-end
`timescale 1ns/10ps
`include "adc_ovs_params.svh"
module adc_oversample_resolution_ctrl_bench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, ext_trigger, watchdog_hit, pready, pslverr, rerr;
  logic temp_sensor_enable, ref_voltage_enable, sample_hold, convert_run, irq_seq_done, irq_watchdog;
  logic [11:0] paddr, level, core_data;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0] core_resolution;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #20 pclk = ~pclk;
  adc_oversample_resolution_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trigger(ext_trigger), .core_data(core_data), .watchdog_hit(watchdog_hit),
    .temp_sensor_enable(temp_sensor_enable), .ref_voltage_enable(ref_voltage_enable),
    .sample_hold(sample_hold), .convert_run(convert_run), .core_resolution(core_resolution),
    .irq_seq_done(irq_seq_done), .irq_watchdog(irq_watchdog));
  analog_core_model core (.convert_run(convert_run), .level(level), .core_data(core_data));
  // ********
  // shared tasks
  // ********
  task report_and_stop;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // starts one edge after entry so a release and the next setup never share a time step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdata & m, exp);
  endtask
  // one start (software or trigger), then n conversions counted phase by phase
  // sp is sampling cycles per conversion, on the control word that switches the converter on
  task run(input logic sw, input int n, input int c, input int sp, input logic [31:0] on);
    int smp, cnv, k, g;
    logic prev;
    apb(1'b1, `OFS_CTRL_B, on);
    // clear old flags so the closing status read proves this run set them
    apb(1'b1, `OFS_STATUS, 32'h0000_0000);
    if (sw) begin
      apb(1'b1, `OFS_CTRL_B, on | 32'h0040_0000);
    end else begin
      @(posedge pclk);
      ext_trigger <= 1'b1;
      @(posedge pclk);
      ext_trigger <= 1'b0;
    end
    smp = 0; cnv = 0; k = 0; g = 0; prev = 1'b0;
    while (k < n && g < 5000) begin
      @(posedge pclk);
      g++;
      if (sample_hold === 1'b1) smp++;
      if (convert_run === 1'b1) cnv++;
      if (prev === 1'b1 && convert_run !== 1'b1) k++;
      prev = convert_run;
    end
    repeat (3) @(posedge pclk);
    check(32'(smp), 32'(n * sp));
    check(32'(cnv), 32'(n * c));
    rd(`OFS_STATUS, 32'h0000_0012, 32'h0000_0012);
  endtask
  function automatic logic [15:0] ovs_exp(int n, int s, logic [11:0] raw);
    logic [19:0] sum;
    sum = 20'(n * raw);
    if (s > 0) sum = sum + 20'(1 << (s - 1));
    return 16'(sum >> s);
  endfunction
  // ********
  // scenarios
  // ********
  task t_reset;
    for (int a = 0; a < 24; a += 4) rd(12'(a), 32'hffff_ffff, 32'h0000_0000);
    rd(12'h018, 32'hffff_ffff, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    check({24'h0, temp_sensor_enable, ref_voltage_enable, sample_hold, convert_run, core_resolution,
      irq_seq_done, irq_watchdog}, 32'h0000_0000);
  endtask
  // longest sampling the field allows; at this clock it still falls short of what the sensor wants
  task t_sensor;
    apb(1'b1, `OFS_SAMPLE, 32'h0000_00ff);
    rd(`OFS_SAMPLE, 32'hffff_ffff, 32'h0000_00ff);
    apb(1'b1, `OFS_CTRL_B, 32'h0080_0000);
    @(negedge pclk);
    check({30'h0, temp_sensor_enable, ref_voltage_enable}, 32'h0000_0003);
    run(1'b1, 1, 13, 256, 32'h0080_0001);
    apb(1'b1, `OFS_CTRL_B, 32'h0000_0000);
    @(negedge pclk);
    check({30'h0, temp_sensor_enable, ref_voltage_enable}, 32'h0000_0000);
    apb(1'b1, `OFS_SAMPLE, 32'h0000_0000);
  endtask
  task t_res;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `OFS_CTRL_B, 32'h0000_0000);
      apb(1'b1, `OFS_CTRL_A, 32'(r) << 24);
      run(1'b1, 1, 13 - 2 * r, 1, 32'h0000_0001);
      check({31'h0, irq_seq_done}, 32'h0000_0000);
    end
    apb(1'b1, `OFS_CTRL_A, 32'h0000_0000);
    rd(`OFS_CTRL_A, 32'h0300_0000, 32'h0300_0000);
    apb(1'b1, `OFS_OVS_CTRL, 32'h0000_0001);
    rd(`OFS_OVS_CTRL, 32'hffff_ffff, 32'h0000_0000);
    apb(1'b1, `OFS_CTRL_B, 32'h0000_0000);
  endtask
  task t_irq;
    apb(1'b1, `OFS_CTRL_A, 32'h0000_0020);
    run(1'b1, 1, 13, 1, 32'h0000_0001);
    check({31'h0, irq_seq_done}, 32'h0000_0001);
    rd(`OFS_RESULT, 32'hffff_ffff, {20'h0, level});
    repeat (2) @(negedge pclk);
    check({31'h0, irq_seq_done}, 32'h0000_0000);
    run(1'b0, 1, 13, 1, 32'h0000_0001);
    apb(1'b1, `OFS_STATUS, 32'h0000_0000);
    rd(`OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
    apb(1'b1, `OFS_CTRL_B, 32'h0000_0000);
  endtask
  task t_wd;
    apb(1'b1, `OFS_CTRL_A, 32'h0000_0000);
    watchdog_hit <= 1'b1;
    @(posedge pclk);
    watchdog_hit <= 1'b0;
    repeat (3) @(negedge pclk);
    check({31'h0, irq_watchdog}, 32'h0000_0000);
    rd(`OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, `OFS_CTRL_A, 32'h0000_0040);
    repeat (2) @(negedge pclk);
    check({31'h0, irq_watchdog}, 32'h0000_0001);
    apb(1'b1, `OFS_STATUS, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    check({31'h0, irq_watchdog}, 32'h0000_0000);
  endtask
  task t_ovs(input int r, input int s, input logic [11:0] raw);
    apb(1'b1, `OFS_CTRL_B, 32'h0000_0000);
    apb(1'b1, `OFS_OVS_CTRL, 32'h0000_0001 | (32'(r) << 2) | (32'(s) << 5));
    level <= raw;
    run(1'b1, 2 << r, 13, 1, 32'h0000_0001);
    rd(`OFS_RESULT, 32'hffff_ffff, {16'h0, ovs_exp(2 << r, s, raw)});
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_trigger = 1'b0;
    watchdog_hit = 1'b0;
    level = 12'ha5c;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_sensor;
    t_res;
    t_irq;
    t_wd;
    for (int r = 0; r < 8; r++) t_ovs(r, 4, 12'hfff);
    for (int s = 0; s < 9; s++) t_ovs(0, s, 12'h005);
    t_ovs(7, 0, 12'hfff);
    t_ovs(2, 3, 12'h801);
    report_and_stop;
  end
endmodule
